// ===== hdl/fpoc_classifier.sv
// operand unpacking, classification and exception flagging for the numeric coprocessor
`timescale 1ns/10ps
module fpoc_classifier (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             err_irq
);

  // shared classification for all float formats
  function automatic fpoc_pkg::fpoc_class_e cls_of(input logic expz, input logic expmax,
      input logic explicit_int, input logic intb, input logic fz, input logic fmsb);
    if (expmax) begin
      if (fz) begin
        cls_of = fpoc_pkg::CLS_INF;
      end else begin
        cls_of = fmsb ? fpoc_pkg::CLS_QNAN : fpoc_pkg::CLS_SNAN;
      end
    end else if (expz) begin
      cls_of = (fz && !intb) ? fpoc_pkg::CLS_ZERO : fpoc_pkg::CLS_DENORM;
    end else if (explicit_int && !intb) begin
      cls_of = fz ? fpoc_pkg::CLS_PZERO : fpoc_pkg::CLS_UNNORM;
    end else begin
      cls_of = fpoc_pkg::CLS_NORMAL;
    end
  endfunction

  // index of the highest set bit of an integer magnitude
  function automatic logic [4:0] msb_idx(input logic [31:0] v);
    msb_idx = 5'h0;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        msb_idx = 5'(i);
      end
    end
  endfunction

  // split a raw operand word by format into sign, true exponent and significand
  function automatic fpoc_pkg::fpoc_op_s unpack(input logic [79:0] raw, input logic [2:0] fmt);
    fpoc_pkg::fpoc_op_s o;
    logic [31:0]        iv;
    logic [31:0]        mag;
    logic [63:0]        sig;
    logic [4:0]         idx;
    o   = '0;
    iv  = 32'h0;
    mag = 32'h0;
    sig = 64'h0;
    idx = 5'h0;
    case (fmt)
      fpoc_pkg::FMT_SHORT: begin
        o.sign = raw[31];
        o.intb = (raw[30:23] != 8'h00);
        o.frac = {raw[22:0], 40'h0};
        // zero exponent weighs as the minimum exponent
        o.exp  = (raw[30:23] == 8'h00) ? 17'sh00001 - fpoc_pkg::BIAS_SHORT
                 : $signed({9'h0, raw[30:23]}) - fpoc_pkg::BIAS_SHORT;
        o.cls  = cls_of(raw[30:23] == 8'h00, raw[30:23] == 8'hff, 1'b0, o.intb,
                        raw[22:0] == 23'h0, raw[22]);
      end
      fpoc_pkg::FMT_LONG: begin
        o.sign = raw[63];
        o.intb = (raw[62:52] != 11'h000);
        o.frac = {raw[51:0], 11'h0};
        o.exp  = (raw[62:52] == 11'h000) ? 17'sh00001 - fpoc_pkg::BIAS_LONG
                 : $signed({6'h0, raw[62:52]}) - fpoc_pkg::BIAS_LONG;
        o.cls  = cls_of(raw[62:52] == 11'h000, raw[62:52] == 11'h7ff, 1'b0, o.intb,
                        raw[51:0] == 52'h0, raw[51]);
      end
      fpoc_pkg::FMT_TEMP: begin
        o.sign = raw[79];
        o.intb = raw[63];
        o.frac = raw[62:0];
        o.exp  = (raw[78:64] == 15'h0000) ? 17'sh00001 - fpoc_pkg::BIAS_TEMP
                 : $signed({2'h0, raw[78:64]}) - fpoc_pkg::BIAS_TEMP;
        o.cls  = cls_of(raw[78:64] == 15'h0000, raw[78:64] == 15'h7fff, 1'b1, raw[63],
                        raw[62:0] == 63'h0, raw[62]);
      end
      fpoc_pkg::FMT_WORD, fpoc_pkg::FMT_SINT: begin
        // integers are held normalised, exponent = index of top magnitude bit
        iv = (fmt == fpoc_pkg::FMT_WORD) ? {{16{raw[15]}}, raw[15:0]}
                                         : raw[31:0];
        o.sign = iv[31];
        mag    = iv[31] ? (32'h0 - iv) : iv;
        idx    = msb_idx(mag);
        sig    = {mag, 32'h0} << (5'd31 - idx);
        o.intb = sig[63];
        o.frac = sig[62:0];
        o.exp  = $signed({12'h0, idx});
        o.cls  = (mag == 32'h0) ? fpoc_pkg::CLS_ZERO : fpoc_pkg::CLS_NORMAL;
      end
      default: o.cls = fpoc_pkg::CLS_EMPTY;
    endcase
    unpack = o;
  endfunction

  function automatic logic is_nan(input fpoc_pkg::fpoc_class_e c);
    is_nan = (c == fpoc_pkg::CLS_QNAN) || (c == fpoc_pkg::CLS_SNAN);
  endfunction

  function automatic logic is_zero(input fpoc_pkg::fpoc_class_e c);
    is_zero = (c == fpoc_pkg::CLS_ZERO) || (c == fpoc_pkg::CLS_PZERO);
  endfunction

  function automatic logic [1:0] tag_of(input fpoc_pkg::fpoc_class_e c);
    if (c == fpoc_pkg::CLS_NORMAL) begin
      tag_of = fpoc_pkg::TAG_VALID;
    end else if (is_zero(c)) begin
      tag_of = fpoc_pkg::TAG_ZERO;
    end else begin
      tag_of = fpoc_pkg::TAG_SPECIAL;
    end
  endfunction

  // software-visible state
  logic [15:0] ctrl_ff;
  logic [5:0]  flags_ff;
  logic [3:0]  cc_ff;           // {c3, c2, c1, c0}
  logic [2:0]  top_ff;
  logic [15:0] tag_ff;
  logic [79:0] opa_ff;
  logic [79:0] opb_ff;
  logic [79:0] res_ff;
  logic [2:0]  cmd_ff;
  logic [2:0]  fmt_ff;
  logic        pend_ff;
  logic [31:0] rdata_ff;
  logic        irq_ff;

  // address decode
  wire wr_ctrl = reg_wr && (reg_addr == fpoc_pkg::OFF_CTRL);
  wire wr_stat = reg_wr && (reg_addr == fpoc_pkg::OFF_STAT);
  wire wr_cmd  = reg_wr && (reg_addr == fpoc_pkg::OFF_CMD);

  // operand decode, both operands share the command's format
  fpoc_pkg::fpoc_op_s opa;
  fpoc_pkg::fpoc_op_s opb;
  assign opa = unpack(opa_ff, fmt_ff);
  assign opb = unpack(opb_ff, fmt_ff);

  wire       affine   = ctrl_ff[fpoc_pkg::CTRL_AFFINE_BIT];
  wire [5:0] mask     = ctrl_ff[5:0];
  wire [2:0] push_top = top_ff - 3'h1;
  wire [1:0] push_tag = tag_ff[{push_top, 1'b0} +: 2];
  wire       a_inf    = (opa.cls == fpoc_pkg::CLS_INF);
  wire       b_inf    = (opb.cls == fpoc_pkg::CLS_INF);
  wire       a_fin    = !a_inf && !is_nan(opa.cls);
  wire       b_fin    = !b_inf && !is_nan(opb.cls);
  wire       any_snan = (opa.cls == fpoc_pkg::CLS_SNAN) || (opb.cls == fpoc_pkg::CLS_SNAN);
  wire       any_qnan = is_nan(opa.cls) || is_nan(opb.cls);
  wire       any_den  = (opa.cls == fpoc_pkg::CLS_DENORM) || (opb.cls == fpoc_pkg::CLS_DENORM);

  // magnitude keys: flipping the exponent sign bit makes them order as unsigned
  wire [80:0] key_a = {opa.exp ^ 17'sh10000, opa.intb, opa.frac};
  wire [80:0] key_b = {opb.exp ^ 17'sh10000, opb.intb, opb.frac};
  wire        both0 = is_zero(opa.cls) && is_zero(opb.cls);
  wire        binf2 = a_inf && b_inf;
  wire        sa    = opa.sign && !is_zero(opa.cls);
  wire        sb    = opb.sign && !is_zero(opb.cls);
  // projective infinities carry no sign, so any two compare equal
  wire cmp_eq = both0 || (binf2 && !affine) || (key_a == key_b && sa == sb);
  wire cmp_lt = (sa != sb) ? sa : (sa ? (key_a > key_b) : (key_a < key_b));
  // projective infinity against a finite number has no ordering
  wire proj_bad = !affine && ((a_inf && b_fin) || (b_inf && a_fin));

  // conversion of operand a to short real, chopping lost bits
  wire [63:0]        sig_a   = {opa.intb, opa.frac};
  wire               tiny    = opa.exp < fpoc_pkg::SHORT_EMIN;
  wire               huge    = opa.exp > fpoc_pkg::SHORT_EMAX;
  wire signed [16:0] dshift  = fpoc_pkg::DEN_SHIFT0 - opa.exp;
  wire               dgone   = dshift >= fpoc_pkg::SIG_BITS;
  wire [63:0]        dsig    = dgone ? 64'h0 : (sig_a >> dshift[5:0]);
  wire               dlost   = dgone ? (sig_a != 64'h0) : ((dsig << dshift[5:0]) != sig_a);
  wire [16:0]        nexp    = opa.exp + fpoc_pkg::BIAS_SHORT;
  wire               a_numbr = (opa.cls == fpoc_pkg::CLS_NORMAL)
                            || (opa.cls == fpoc_pkg::CLS_DENORM)
                            || (opa.cls == fpoc_pkg::CLS_UNNORM);

  // execution of the pending command
  logic [5:0]  ev;
  logic [3:0]  nxt_cc;
  logic        cc_we;
  logic [79:0] nxt_res;
  logic        res_we;
  logic [2:0]  nxt_top;
  logic [15:0] nxt_tag;
  always_comb begin
    ev      = 6'h00;
    nxt_cc  = cc_ff;
    cc_we   = 1'b0;
    nxt_res = res_ff;
    res_we  = 1'b0;
    nxt_top = top_ff;
    nxt_tag = tag_ff;
    if (pend_ff) begin
      case (cmd_ff)
        fpoc_pkg::CMD_EXAM: begin
          cc_we  = 1'b1;
          nxt_cc = {opa.cls[2], opa.cls[1], opa.sign, opa.cls[0]};
        end
        fpoc_pkg::CMD_LOAD: begin
          // pushing onto an occupied slot is a stack overflow
          if (push_tag != fpoc_pkg::TAG_EMPTY) begin
            ev[fpoc_pkg::EXC_INV] = 1'b1;
          end else begin
            nxt_top = push_top;
            nxt_tag[{push_top, 1'b0} +: 2] = tag_of(opa.cls);
          end
          ev[fpoc_pkg::EXC_INV] = ev[fpoc_pkg::EXC_INV] | (opa.cls == fpoc_pkg::CLS_SNAN);
        end
        fpoc_pkg::CMD_FREE: begin
          nxt_tag[{top_ff, 1'b0} +: 2] = fpoc_pkg::TAG_EMPTY;
          nxt_top = top_ff + 3'h1;
        end
        fpoc_pkg::CMD_CMP: begin
          cc_we = 1'b1;
          ev[fpoc_pkg::EXC_INV] = any_snan || proj_bad;
          ev[fpoc_pkg::EXC_DEN] = any_den;
          if (any_qnan || proj_bad) begin
            nxt_cc = 4'b1101;                           // unordered
          end else if (cmp_eq) begin
            nxt_cc = 4'b1000;
          end else begin
            nxt_cc = {3'b000, cmp_lt};
          end
        end
        fpoc_pkg::CMD_DIV: begin
          ev[fpoc_pkg::EXC_DEN] = any_den;
          if (any_snan || (binf2) || both0) begin
            ev[fpoc_pkg::EXC_INV] = 1'b1;
            res_we  = mask[fpoc_pkg::EXC_INV];
            nxt_res = fpoc_pkg::TEMP_INDEF;
          end else if (any_qnan) begin
            res_we  = 1'b1;
            nxt_res = fpoc_pkg::TEMP_INDEF;
          end else if (a_fin && !is_zero(opa.cls) && is_zero(opb.cls)) begin
            ev[fpoc_pkg::EXC_ZDIV] = 1'b1;
            res_we  = mask[fpoc_pkg::EXC_ZDIV];
            nxt_res = {opa.sign ^ opb.sign, fpoc_pkg::TEMP_INF};
          end
        end
        fpoc_pkg::CMD_STORE: begin
          res_we  = 1'b1;
          nxt_res = 80'h0;
          nxt_res[31] = opa.sign;
          if (is_nan(opa.cls)) begin
            ev[fpoc_pkg::EXC_INV] = (opa.cls == fpoc_pkg::CLS_SNAN);
            nxt_res[31:0] = fpoc_pkg::SHORT_INDEF;
          end else if (opa.cls == fpoc_pkg::CLS_INF) begin
            nxt_res[30:23] = 8'hff;
          end else if (a_numbr && sig_a != 64'h0 && huge) begin
            ev[fpoc_pkg::EXC_OVF] = 1'b1;
            nxt_res[30:23] = 8'hff;
          end else if (a_numbr && sig_a != 64'h0 && tiny) begin
            ev[fpoc_pkg::EXC_UNF]  = 1'b1;
            ev[fpoc_pkg::EXC_PREC] = dlost;
            nxt_res[22:0] = dsig[22:0];
          end else if (a_numbr && sig_a != 64'h0) begin
            ev[fpoc_pkg::EXC_PREC] = (sig_a[39:0] != 40'h0);
            nxt_res[30:23] = nexp[7:0];
            nxt_res[22:0]  = sig_a[62:40];
          end
        end
        default: ev = 6'h00;
      endcase
    end
  end

  // status write by software, events set over the clear
  wire [5:0] nxt_flags = (wr_stat ? reg_wdata[5:0] : flags_ff) | ev;
  wire [3:0] stat_cc   = {reg_wdata[fpoc_pkg::ST_C3], reg_wdata[fpoc_pkg::ST_C2],
                          reg_wdata[fpoc_pkg::ST_C1], reg_wdata[fpoc_pkg::ST_C0]};
  wire [3:0] nxt_cc_r  = cc_we ? nxt_cc : (wr_stat ? stat_cc : cc_ff);
  wire [2:0] nxt_top_r = pend_ff ? nxt_top
                       : (wr_stat ? reg_wdata[fpoc_pkg::ST_TOP +: 3] : top_ff);
  wire       pend_irq  = |(flags_ff & ~mask);

  // status word image
  wire [15:0] stat_word = {pend_ff, cc_ff[3], top_ff, cc_ff[2], cc_ff[1], cc_ff[0],
                           pend_irq, 1'b0, flags_ff};

  // read mux, unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      fpoc_pkg::OFF_CTRL:  rd_mux = {16'h0, ctrl_ff};
      fpoc_pkg::OFF_STAT:  rd_mux = {16'h0, stat_word};
      fpoc_pkg::OFF_TAG:   rd_mux = {16'h0, tag_ff};
      fpoc_pkg::OFF_OPA0:  rd_mux = opa_ff[31:0];
      fpoc_pkg::OFF_OPA1:  rd_mux = opa_ff[63:32];
      fpoc_pkg::OFF_OPA2:  rd_mux = {16'h0, opa_ff[79:64]};
      fpoc_pkg::OFF_OPB0:  rd_mux = opb_ff[31:0];
      fpoc_pkg::OFF_OPB1:  rd_mux = opb_ff[63:32];
      fpoc_pkg::OFF_OPB2:  rd_mux = {16'h0, opb_ff[79:64]};
      fpoc_pkg::OFF_CMD:   rd_mux = {25'h0, fmt_ff, 1'b0, cmd_ff};
      fpoc_pkg::OFF_CLASS: rd_mux = {opa.exp[15:0], 8'h0, opb.cls, opa.cls};
      fpoc_pkg::OFF_RES0:  rd_mux = res_ff[31:0];
      fpoc_pkg::OFF_RES1:  rd_mux = res_ff[63:32];
      fpoc_pkg::OFF_RES2:  rd_mux = {16'h0, res_ff[79:64]};
      default:             rd_mux = 32'h0;
    endcase
  end

  // control and operand registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_ff <= fpoc_pkg::CTRL_RST;
      opa_ff  <= 80'h0;
      opb_ff  <= 80'h0;
    end else begin
      if (wr_ctrl) ctrl_ff <= reg_wdata[15:0];
      if (reg_wr && reg_addr == fpoc_pkg::OFF_OPA0) opa_ff[31:0]  <= reg_wdata;
      if (reg_wr && reg_addr == fpoc_pkg::OFF_OPA1) opa_ff[63:32] <= reg_wdata;
      if (reg_wr && reg_addr == fpoc_pkg::OFF_OPA2) opa_ff[79:64] <= reg_wdata[15:0];
      if (reg_wr && reg_addr == fpoc_pkg::OFF_OPB0) opb_ff[31:0]  <= reg_wdata;
      if (reg_wr && reg_addr == fpoc_pkg::OFF_OPB1) opb_ff[63:32] <= reg_wdata;
      if (reg_wr && reg_addr == fpoc_pkg::OFF_OPB2) opb_ff[79:64] <= reg_wdata[15:0];
    end
  end

  // command capture; execution happens one cycle later while busy shows
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_ff  <= fpoc_pkg::CMD_NOP;
      fmt_ff  <= fpoc_pkg::FMT_SHORT;
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= wr_cmd;
      if (wr_cmd) begin
        cmd_ff <= reg_wdata[fpoc_pkg::CMD_OP_LSB +: 3];
        fmt_ff <= reg_wdata[fpoc_pkg::CMD_FMT_LSB +: 3];
      end
    end
  end

  // status, tag and result state
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_ff <= 6'h00;
      cc_ff    <= 4'h0;
      top_ff   <= 3'h0;
      tag_ff   <= fpoc_pkg::TAG_RST;
      res_ff   <= fpoc_pkg::RES_RST;
    end else begin
      flags_ff <= nxt_flags;
      cc_ff    <= nxt_cc_r;
      top_ff   <= nxt_top_r;
      tag_ff   <= nxt_tag;
      if (res_we) res_ff <= nxt_res;
    end
  end

  // registered outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= 32'h0;
      irq_ff   <= 1'b0;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 32'h0;
      irq_ff   <= pend_irq;
    end
  end

  assign reg_rdata = rdata_ff;
  assign err_irq   = irq_ff;

endmodule // fpoc_classifier

// ===== include/fpoc_pkg.sv
// constants, field layouts and types for the operand classifier
package fpoc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_STAT  = 8'h04;
  localparam logic [7:0] OFF_TAG   = 8'h08;
  localparam logic [7:0] OFF_OPA0  = 8'h0c;
  localparam logic [7:0] OFF_OPA1  = 8'h10;
  localparam logic [7:0] OFF_OPA2  = 8'h14;
  localparam logic [7:0] OFF_OPB0  = 8'h18;
  localparam logic [7:0] OFF_OPB1  = 8'h1c;
  localparam logic [7:0] OFF_OPB2  = 8'h20;
  localparam logic [7:0] OFF_CMD   = 8'h24;
  localparam logic [7:0] OFF_CLASS = 8'h28;
  localparam logic [7:0] OFF_RES0  = 8'h2c;
  localparam logic [7:0] OFF_RES1  = 8'h30;
  localparam logic [7:0] OFF_RES2  = 8'h34;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h003f;
  localparam logic [15:0] TAG_RST  = 16'hffff;
  localparam logic [79:0] RES_RST  = 80'h0;
  // control word fields
  localparam int CTRL_AFFINE_BIT = 12;
  // exception flag positions (status and mask alike)
  localparam int EXC_INV  = 0;
  localparam int EXC_DEN  = 1;
  localparam int EXC_ZDIV = 2;
  localparam int EXC_OVF  = 3;
  localparam int EXC_UNF  = 4;
  localparam int EXC_PREC = 5;
  // status word fields
  localparam int ST_IRQ  = 7;
  localparam int ST_C0   = 8;
  localparam int ST_C1   = 9;
  localparam int ST_C2   = 10;
  localparam int ST_TOP  = 11;
  localparam int ST_C3   = 14;
  localparam int ST_BUSY = 15;
  // command register fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_FMT_LSB = 4;
  // exponent biases and single-precision limits
  localparam logic signed [16:0] BIAS_SHORT = 17'sh0007f;
  localparam logic signed [16:0] BIAS_LONG  = 17'sh003ff;
  localparam logic signed [16:0] BIAS_TEMP  = 17'sh03fff;
  localparam logic signed [16:0] SHORT_EMIN = -17'sh0007e;
  localparam logic signed [16:0] SHORT_EMAX = 17'sh0007f;
  localparam logic signed [16:0] DEN_SHIFT0 = -17'sh00056;
  localparam logic signed [16:0] SIG_BITS   = 17'sh00040;
  // masked invalid answers (indefinite) and the masked zero-divide infinity
  localparam logic [79:0] TEMP_INDEF  = 80'hffff_c000_0000_0000_0000;
  localparam logic [31:0] SHORT_INDEF = 32'hffc0_0000;
  localparam logic [78:0] TEMP_INF    = 79'h7fff_8000_0000_0000_0000;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000, CMD_EXAM = 3'b001, CMD_LOAD = 3'b010, CMD_FREE = 3'b011,
    CMD_CMP = 3'b100, CMD_DIV  = 3'b101, CMD_STORE = 3'b110
  } fpoc_cmd_e;

  typedef enum logic [2:0] {
    FMT_SHORT = 3'b000, FMT_LONG = 3'b001, FMT_TEMP = 3'b010,
    FMT_WORD  = 3'b011, FMT_SINT = 3'b100
  } fpoc_fmt_e;

  typedef enum logic [3:0] {
    CLS_ZERO  = 4'h0, CLS_NORMAL = 4'h1, CLS_DENORM = 4'h2, CLS_UNNORM = 4'h3,
    CLS_PZERO = 4'h4, CLS_INF    = 4'h5, CLS_QNAN   = 4'h6, CLS_SNAN   = 4'h7,
    CLS_EMPTY = 4'h8
  } fpoc_class_e;

  localparam logic [1:0] TAG_VALID   = 2'h0;
  localparam logic [1:0] TAG_ZERO    = 2'h1;
  localparam logic [1:0] TAG_SPECIAL = 2'h2;
  localparam logic [1:0] TAG_EMPTY   = 2'h3;

  // unpacked operand in a common extended-like form
  typedef struct packed {
    logic               sign;
    logic signed [16:0] exp;
    logic               intb;
    logic [62:0]        frac;
    fpoc_class_e        cls;
  } fpoc_op_s;
endpackage

// ===== tb/fpoc_classifier_asserts.sv
// concurrent checks on the classifier register port and interrupt line
`timescale 1ns/10ps
module fpoc_classifier_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        err_irq
);
  logic [31:0] ctrl_ff;
  // shadow control word, so readback is judged against what was written
  always_ff @(posedge mclk) begin
    if (rst)
      ctrl_ff <= {16'h0, fpoc_pkg::CTRL_RST};
    else if (reg_wr && reg_addr == fpoc_pkg::OFF_CTRL)
      ctrl_ff <= reg_wdata;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside the read cycle");
  rdata_rst_a: assert property ($past(rst) |-> reg_rdata == 32'h0)
    else $error("read data not clear after reset");
  irq_rst_a: assert property ($fell(rst) |-> !err_irq)
    else $error("interrupt up after reset");
  unmap_zero_a: assert property (reg_rd && reg_addr > fpoc_pkg::OFF_RES2 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  mask_quiet_a: assert property (reg_wr && reg_addr == fpoc_pkg::OFF_CTRL
    && reg_wdata[5:0] == 6'h3f |=> ##1 !err_irq)
    else $error("interrupt with all masks set");
  irq_cause_a: assert property ($changed(err_irq) |-> $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("interrupt moved without a write");
  ctrl_back_a: assert property (reg_rd && reg_addr == fpoc_pkg::OFF_CTRL
    |=> {reg_rdata[12], reg_rdata[5:0]} == {ctrl_ff[12], ctrl_ff[5:0]})
    else $error("control readback wrong");
  busy_flag_a: assert property (reg_wr && reg_addr == fpoc_pkg::OFF_CMD
    && reg_wdata[2:0] inside {[3'h1:3'h6]} ##1 reg_rd && reg_addr == fpoc_pkg::OFF_STAT
    |=> reg_rdata[15])
    else $error("busy not shown during execution");
endmodule // fpoc_classifier_chk
bind fpoc_classifier fpoc_classifier_chk fpoc_classifier_chk_inst (.mclk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .err_irq);

// ===== tb/fpoc_classifier_tb_top.sv
// self-checking bench for the operand classifier
`timescale 1ns/10ps
module fpoc_classifier_tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        err_irq;
  int          error_cnt = 0;
  int          cmp_count = 0;
  // 10 MHz clock
  always #50 mclk = ~mclk;
  fpoc_classifier fpoc_classifier_inst (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .err_irq);
  fpoc_host fpoc_host_inst (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  // compare, count, report
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    fpoc_host_inst.rd(a, d);
    chk(d & m, e);
  endtask
  // clear flags but keep the stack top, load operands, issue command; busy poll is bounded
  task automatic op(input logic [6:0] c, input logic [79:0] a, input logic [79:0] b);
    logic [31:0] d;
    fpoc_host_inst.rd(fpoc_pkg::OFF_STAT, d);
    fpoc_host_inst.wr(fpoc_pkg::OFF_STAT, d & 32'h3800);
    fpoc_host_inst.wr(fpoc_pkg::OFF_OPA0, a[31:0]);
    fpoc_host_inst.wr(fpoc_pkg::OFF_OPA1, a[63:32]);
    fpoc_host_inst.wr(fpoc_pkg::OFF_OPA2, {16'h0, a[79:64]});
    fpoc_host_inst.wr(fpoc_pkg::OFF_OPB0, b[31:0]);
    fpoc_host_inst.wr(fpoc_pkg::OFF_OPB1, b[63:32]);
    fpoc_host_inst.wr(fpoc_pkg::OFF_OPB2, {16'h0, b[79:64]});
    // read right after the command, while it executes
    fpoc_host_inst.wr_rd(fpoc_pkg::OFF_CMD, {25'h0, c}, fpoc_pkg::OFF_STAT, d);
    chk({31'h0, d[15]}, 32'h1);
    for (int i = 0; i < 8 && d[15] !== 1'b0; i++)
      fpoc_host_inst.rd(fpoc_pkg::OFF_STAT, d);
    if (d[15] !== 1'b0) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic t_reset();
    rchk(fpoc_pkg::OFF_CTRL, 32'hffff, 32'h003f);
    rchk(fpoc_pkg::OFF_STAT, 32'hffff, 32'h0);
    fpoc_host_inst.wr(fpoc_pkg::OFF_TAG, 32'h0);
    rchk(fpoc_pkg::OFF_TAG, 32'hffff, 32'hffff);
    rchk(8'h3c, 32'hffffffff, 32'h0);
    $display("test reset done");
  endtask
  // e: [31:16] true exponent, [14:12] format, [11] exponent checked, [3:0] class
  task automatic t_class();
    logic [79:0] v [10] = '{80'h4080_0000, 80'h1, 80'h7f80_0000, 80'h7fc0_0000, 80'h7fa0_0000,
      {16'h1, 64'h1}, {16'h1, 64'h0}, {16'h0, 64'h1}, {16'h4002, 64'hc000_0000_0000_0000},
      80'h4000_0000_0000_0000};
    logic [31:0] e [10] = '{32'h0002_0801, 32'hff82_0802, 32'h5, 32'h6, 32'h7, 32'h2003,
      32'h2004, 32'h2002, 32'h0003_2801, 32'h0001_1801};
    logic [31:0] m;
    logic [31:0] x;
    for (int i = 0; i < 10; i++) begin
      m = {{16{e[i][11]}}, 16'h000f};
      // examine puts class bits 2,1,0 into c3, c2, c0 and the sign into c1
      x = {17'h0, e[i][2], 3'h0, e[i][1], 1'b0, e[i][0], 8'h0};
      op({e[i][14:12], 4'h1}, v[i], 80'h0);
      rchk(fpoc_pkg::OFF_CLASS, 32'hf, e[i] & 32'hf);
      rchk(fpoc_pkg::OFF_CLASS, m, e[i] & m);
      rchk(fpoc_pkg::OFF_STAT, 32'h4700, x);
    end
    $display("test class done");
  endtask
  task automatic t_cmp();
    logic [31:0] c [4] = '{32'h003f, 32'h103f, 32'h003f, 32'h103f};
    logic [31:0] b [4] = '{32'h3f80_0000, 32'h3f80_0000, 32'hff80_0000, 32'hff80_0000};
    logic [31:0] x [4] = '{32'h4501, 32'h0, 32'h4000, 32'h0};
    for (int i = 0; i < 4; i++) begin
      fpoc_host_inst.wr(fpoc_pkg::OFF_CTRL, c[i]);
      rchk(fpoc_pkg::OFF_CTRL, 32'h103f, c[i]);
      op(7'h04, 80'h7f80_0000, {48'h0, b[i]});
      rchk(fpoc_pkg::OFF_STAT, 32'h4701, x[i]);
    end
    fpoc_host_inst.wr(fpoc_pkg::OFF_CTRL, 32'h003e);
    op(7'h04, 80'h7fa0_0000, 80'h3f80_0000);
    rchk(fpoc_pkg::OFF_STAT, 32'h4701, 32'h4501);
    chk({31'h0, err_irq}, 32'h1);
    fpoc_host_inst.wr(fpoc_pkg::OFF_STAT, 32'h0);
    rchk(fpoc_pkg::OFF_STAT, 32'h003f, 32'h0);
    chk({31'h0, err_irq}, 32'h0);
    fpoc_host_inst.wr(fpoc_pkg::OFF_CTRL, 32'h003f);
    op(7'h04, 80'h7fa0_0000, 80'h3f80_0000);
    chk({31'h0, err_irq}, 32'h0);
    op(7'h44, 80'hffff_ffff, 80'h1);
    rchk(fpoc_pkg::OFF_STAT, 32'h4701, 32'h0100);
    op(7'h34, 80'hffff, 80'h1);
    rchk(fpoc_pkg::OFF_STAT, 32'h4701, 32'h0100);
    $display("test compare done");
  endtask
  task automatic t_arith();
    op(7'h05, 80'h3f80_0000, 80'h0);
    rchk(fpoc_pkg::OFF_STAT, 32'h0005, 32'h0004);
    rchk(fpoc_pkg::OFF_RES1, 32'hffffffff, 32'h8000_0000);
    rchk(fpoc_pkg::OFF_RES2, 32'hffff, 32'h7fff);
    fpoc_host_inst.wr(fpoc_pkg::OFF_CTRL, 32'h002f);
    op(7'h26, {16'h3f7e, 64'h8000_0000_0000_0000}, 80'h0);
    rchk(fpoc_pkg::OFF_STAT, 32'h0011, 32'h0010);
    rchk(fpoc_pkg::OFF_RES0, 32'hffffffff, 32'h0010_0000);
    chk({31'h0, err_irq}, 32'h1);
    // masking the pending flag must drop the request
    fpoc_host_inst.wr(fpoc_pkg::OFF_CTRL, 32'h003f);
    rchk(fpoc_pkg::OFF_CTRL, 32'h003f, 32'h003f);
    chk({31'h0, err_irq}, 32'h0);
    $display("test arith done");
  endtask
  task automatic t_tag();
    op(7'h02, 80'h0, 80'h0);
    rchk(fpoc_pkg::OFF_TAG, 32'hffff, 32'h7fff);
    op(7'h02, 80'h3f80_0000, 80'h0);
    rchk(fpoc_pkg::OFF_TAG, 32'hffff, 32'h4fff);
    op(7'h03, 80'h0, 80'h0);
    rchk(fpoc_pkg::OFF_TAG, 32'hffff, 32'h7fff);
    $display("test tag done");
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_class();
    t_cmp();
    t_arith();
    t_tag();
    test_done();
  end
endmodule // fpoc_classifier_tb_top

// ===== tb/fpoc_host.sv
// host core model: drives the register port as the processor would
`timescale 1ns/10ps
module fpoc_host (
  input  wire logic        mclk,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  // quiet bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // one-cycle write strobe, dropped at the edge that takes it, so it never repeats
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe, taken at its closing edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;          // released lines must not keep the last value
    reg_wdata <= ~reg_wdata;
    @(posedge mclk);
    d = reg_rdata;
  endtask
  // write then read with no gap, so the read lands in the cycle right after
  task automatic wr_rd(input logic [7:0] wa, input logic [31:0] wd, input logic [7:0] ra,
      output logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    reg_addr  <= wa;
    reg_wdata <= wd;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    reg_addr  <= ra;
    @(posedge mclk);
    reg_rd    <= 1'b0;
    reg_addr  <= ~ra;
    reg_wdata <= ~wd;
    @(posedge mclk);
    d = reg_rdata;
  endtask
endmodule // fpoc_host
